// *** hw/acc_ctrl.sv ***
// converter channel select and control/status block, apb register slave
// assumes apb master on core_clk, analog sar delivers its result on sar_result
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module acc_ctrl
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [DATA_W-1:0]    pwdata,
  output var  logic [DATA_W-1:0]    prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  // trigger sources, index = source code
  input  wire logic [7:1]           trig_in,
  // interrupt system
  input  wire logic                 cpu_irq_global_en,
  input  wire logic                 irq_ack,
  output var  logic                 irq_req,
  // analog front end
  input  wire logic [RES_W-1:0]     sar_result,
  output var  logic                 adc_power,
  output var  logic                 adc_start,
  output var  logic                 adc_busy,
  output var  logic                 adc_single,
  output var  logic                 adc_diff,
  output var  logic                 adc_bandgap,
  output var  logic                 adc_ground,
  output var  logic [2:0]           adc_pos,
  output var  logic [2:0]           adc_neg,
  output var  acc_gain_e            adc_gain
);
  import acc_pkg::*;

  // ==================== register state
  logic [2:0]        select_upper;
  logic [CODE_W-1:0] channel_gain_code;
  logic              converter_on;
  logic              auto_trigger_on;
  logic              conversion_done_flag;
  logic              conversion_done_irq_en;
  logic [DIV_W-1:0]  converter_clock_divider;
  logic [TS_W-1:0]   trigger_source_sel;
  logic [RES_W-1:0]  result;
  logic              result_lock;

  // ==================== conversion state
  acc_state_e        state;
  logic [CODE_W-1:0] active_code;
  logic [4:0]        conv_cnt;
  logic [4:0]        conv_len;
  logic              first_pending;
  logic              trig_prev;

  // ==================== combinational terms
  logic              acc_en;
  logic              wr_en;
  logic              rd_en;
  logic              wr_ctrl;
  logic              rd_low;
  logic              rd_high;
  logic              next_on;
  logic              abort;
  logic              use_long;
  logic              trig_level;
  logic              trig_edge;
  logic              sw_start;
  logic              trig_start;
  logic              done_now;
  logic              free_restart;
  logic              begin_conv;
  logic              next_flag;
  logic              addr_hit;
  logic [7:0]        rd_value;
  logic              dec_single;
  logic              dec_diff;
  logic              dec_bandgap;
  logic              dec_ground;
  logic [2:0]        dec_pos;
  logic [2:0]        dec_neg;
  acc_gain_e         dec_gain;

  acc_tick_if tk ();

  // ==================== apb decode
  // one wait state: access cycle with pready low, then pready high
  assign acc_en  = psel && penable && pready;
  assign wr_en   = acc_en && pwrite;
  assign rd_en   = acc_en && !pwrite;
  assign wr_ctrl = wr_en && (paddr == OFF_CTRL);
  assign rd_low  = rd_en && (paddr == OFF_RES_LOW);
  assign rd_high = rd_en && (paddr == OFF_RES_HIGH);

  // read value and address check
  always_comb begin
    addr_hit = 1'b1;
    rd_value = REG_RESET;
    case (paddr)
      OFF_SELECT:   rd_value = {select_upper, channel_gain_code};
      OFF_CTRL:     rd_value = {converter_on, adc_busy, auto_trigger_on, conversion_done_flag,
                                conversion_done_irq_en, converter_clock_divider};
      OFF_CTRL_B:   rd_value = {5'h00, trigger_source_sel};
      OFF_RES_LOW:  rd_value = result[7:0];
      OFF_RES_HIGH: rd_value = {6'h00, result[RES_W-1:8]};
      default:      addr_hit = 1'b0;
    endcase
  end

  // ready, error and read data
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !addr_hit;
      prdata  <= pwrite ? '0 : {24'h000000, rd_value};
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ==================== start and stop terms
  // written enable value, clearing aborts
  assign next_on  = wr_ctrl ? pwdata[ON_BIT] : converter_on;
  assign abort    = (state == ACC_CONV) && !next_on;
  // long first conversion, also when enabled with start
  assign use_long = first_pending || !converter_on;

  assign trig_level = (trigger_source_sel == TS_FREE) ? 1'b0 : trig_in[trigger_source_sel];
  assign trig_edge  = trig_level && !trig_prev;

  assign sw_start   = wr_ctrl && pwdata[GO_BIT] && pwdata[ON_BIT];
  assign trig_start = converter_on && auto_trigger_on && trig_edge;

  assign done_now     = (state == ACC_CONV) && tk.tick && (conv_cnt == conv_len - 5'h01) && next_on;
  // free running chains the next conversion
  assign free_restart = done_now && auto_trigger_on && (trigger_source_sel == TS_FREE);
  assign begin_conv   = ((state != ACC_CONV) && next_on && (sw_start || trig_start)) || free_restart;

  // set on completion; clears, set wins
  always_comb begin
    next_flag = conversion_done_flag;
    if (done_now) begin
      next_flag = 1'b1;
    end else if ((wr_ctrl && pwdata[FLAG_BIT]) || irq_ack) begin
      next_flag = 1'b0;
    end
  end

  // ==================== software registers
  // input select and trigger source
  always_ff @(posedge core_clk) begin
    if (reset) begin
      select_upper       <= REG_RESET[2:0];
      channel_gain_code  <= REG_RESET[CODE_W-1:0];
      trigger_source_sel <= REG_RESET[TS_W-1:0];
    end else if (wr_en && (paddr == OFF_SELECT)) begin
      select_upper       <= pwdata[7:5];
      channel_gain_code  <= pwdata[CODE_W-1:0];
    end else if (wr_en && (paddr == OFF_CTRL_B)) begin
      trigger_source_sel <= pwdata[TS_W-1:0];
    end
  end

  // control/status plain bits
  always_ff @(posedge core_clk) begin
    if (reset) begin
      converter_on            <= REG_RESET[ON_BIT];
      auto_trigger_on         <= REG_RESET[AUTO_BIT];
      conversion_done_irq_en  <= REG_RESET[IE_BIT];
      converter_clock_divider <= REG_RESET[DIV_W-1:0];
      conversion_done_flag    <= REG_RESET[FLAG_BIT];
    end else begin
      conversion_done_flag <= next_flag;
      if (wr_ctrl) begin
        converter_on            <= pwdata[ON_BIT];
        auto_trigger_on         <= pwdata[AUTO_BIT];
        conversion_done_irq_en  <= pwdata[IE_BIT];
        converter_clock_divider <= pwdata[DIV_W-1:0];
      end
    end
  end

  // request gated by flag and both enables
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= next_flag && (wr_ctrl ? pwdata[IE_BIT] : conversion_done_irq_en) && cpu_irq_global_en;
    end
  end

  // ==================== conversion sequencing
  // state machine
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= ACC_OFF;
    end else begin
      case (state)
        ACC_OFF:  state <= !next_on ? ACC_OFF : (begin_conv ? ACC_CONV : ACC_IDLE);
        ACC_IDLE: state <= !next_on ? ACC_OFF : (begin_conv ? ACC_CONV : ACC_IDLE);
        ACC_CONV: state <= !next_on ? ACC_OFF : ((done_now && !free_restart) ? ACC_IDLE : ACC_CONV);
        default:  state <= ACC_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      conv_cnt      <= 5'h00;
      conv_len      <= NORMAL_LEN;
      first_pending <= 1'b0;
    end else begin
      if (begin_conv) begin
        conv_cnt      <= 5'h00;
        conv_len      <= use_long ? FIRST_LEN : NORMAL_LEN;
        first_pending <= 1'b0;
      end else begin
        if ((state == ACC_CONV) && tk.tick) begin
          conv_cnt <= conv_cnt + 5'h01;
        end
        if (!converter_on && next_on) begin
          first_pending <= 1'b1;
        end
      end
    end
  end

  // busy bit; cleared with flag set, or on abort without flag
  always_ff @(posedge core_clk) begin
    if (reset) begin
      adc_busy  <= 1'b0;
      adc_start <= 1'b0;
      adc_power <= 1'b0;
    end else begin
      adc_start <= begin_conv;
      adc_power <= next_on;
      if (begin_conv) begin
        adc_busy <= 1'b1;
      end else if (done_now || abort) begin
        adc_busy <= 1'b0;
      end
    end
  end

  // low read locks, high read releases
  always_ff @(posedge core_clk) begin
    if (reset) begin
      result_lock <= 1'b0;
    end else if (rd_low) begin
      result_lock <= 1'b1;
    end else if (rd_high) begin
      result_lock <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      result <= '0;
    end else if (done_now && !result_lock) begin
      result <= sar_result;
    end
  end

  // trigger history for edge detection
  always_ff @(posedge core_clk) begin
    if (reset) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_level;
    end
  end

  // ==================== channel path
  // code held while converting
  always_ff @(posedge core_clk) begin
    if (reset) begin
      active_code <= REG_RESET[CODE_W-1:0];
    end else if ((state != ACC_CONV) || done_now) begin
      active_code <= channel_gain_code;
    end
  end

  acc_channel_decode u_decode (
    .code    (active_code),
    .single  (dec_single),
    .diff    (dec_diff),
    .bandgap (dec_bandgap),
    .ground  (dec_ground),
    .pos     (dec_pos),
    .neg     (dec_neg),
    .gain    (dec_gain)
  );

  // registered switch settings
  always_ff @(posedge core_clk) begin
    if (reset) begin
      adc_single  <= 1'b0;
      adc_diff    <= 1'b0;
      adc_bandgap <= 1'b0;
      adc_ground  <= 1'b0;
      adc_pos     <= 3'h0;
      adc_neg     <= 3'h0;
      adc_gain    <= ACC_GAIN_1X;
    end else begin
      adc_single  <= dec_single;
      adc_diff    <= dec_diff;
      adc_bandgap <= dec_bandgap;
      adc_ground  <= dec_ground;
      adc_pos     <= dec_pos;
      adc_neg     <= dec_neg;
      adc_gain    <= dec_gain;
    end
  end

  // ==================== converter clock
  // divider runs while enabled, realigned at start
  assign tk.run      = converter_on;
  assign tk.restart  = begin_conv;
  assign tk.div_code = converter_clock_divider;

  acc_prescaler #(.CNT_W(7)) u_prescaler (
    .core_clk (core_clk),
    .reset    (reset),
    .tk       (tk)
  );

  // ==================== checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  flag_on_done_a: assert property (done_now |=> conversion_done_flag)
    else $error("done flag not set at completion");
  go_clears_a: assert property (done_now && !free_restart |=> !adc_busy && conversion_done_flag)
    else $error("start bit and flag not updated together");
  result_load_a: assert property (done_now && !result_lock |=> result == $past(sar_result))
    else $error("result not loaded at completion");
  abort_stops_a: assert property (abort |=> state == ACC_OFF && !adc_busy && !$rose(conversion_done_flag))
    else $error("disable did not abort conversion");
  irq_gate_a: assert property (irq_req |-> conversion_done_flag && conversion_done_irq_en)
    else $error("interrupt requested without flag and enable");
  flag_zero_a: assert property (conversion_done_flag && wr_ctrl && !pwdata[FLAG_BIT] && !irq_ack
                                |=> conversion_done_flag)
    else $error("zero write cleared done flag");
  first_len_a: assert property (begin_conv && use_long |=> conv_len == FIRST_LEN && adc_busy)
    else $error("first conversion not long");
  lock_hold_a: assert property (result_lock && !rd_high |=> $stable(result))
    else $error("result changed while locked");
  chan_hold_a: assert property (state == ACC_CONV && !done_now |=> $stable(active_code))
    else $error("channel changed mid-conversion");

  cover_first_c: cover property (begin_conv && use_long ##[1:1000] done_now);
  cover_free_c:  cover property (free_restart);
  cover_trig_c:  cover property (trig_start && !sw_start);
  cover_abort_c: cover property (abort);

endmodule : acc_ctrl
`default_nettype wire

// *** hw/acc_pkg.sv ***
// converter channel and control constants, types and register map
// assumes one 250 MHz core clock and an apb master with 32-bit data
// What this block does
// - channel code written mid-conversion applies only after that conversion completes.
// - codes 0 to 7 pick single inputs 0-7; 30 bandgap; 31 ground.
// - codes 8 to 29 pick differential pairs with gain; same-input codes measure offset.
// - enable bit 7 powers converter; clearing it aborts a running conversion.
// - writing start bit 6 begins one conversion, or the first of free running.
// - first conversion after enabling lasts 25 converter clocks, later ones 13.
// - start bit reads one while converting, zero after; writing zero does nothing.
// - with auto trigger bit 5 set, rising edge of chosen trigger starts conversion.
// - done flag bit 4 sets when conversion ends; result is updated too unless locked.
// - done flag clears on vector acknowledge or written one; zero leaves it.
// - interrupt request only while flag, enable bit 3 and global enable set.
// - three-bit divider: codes 0,1 divide by 2, then 4 up to 128.
// - trigger source codes: free running, comparator, ext int 0, timer events.
// - after low result byte read, result updates block until high byte read.
package acc_pkg;

  // ==================== bus and register map
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam logic [7:0]  OFF_SELECT   = 8'h00;
  localparam logic [7:0]  OFF_CTRL     = 8'h04;
  localparam logic [7:0]  OFF_CTRL_B   = 8'h08;
  localparam logic [7:0]  OFF_RES_LOW  = 8'h0c;
  localparam logic [7:0]  OFF_RES_HIGH = 8'h10;

  // ==================== field positions and reset values
  localparam int          ON_BIT       = 7;
  localparam int          GO_BIT       = 6;
  localparam int          AUTO_BIT     = 5;
  localparam int          FLAG_BIT     = 4;
  localparam int          IE_BIT       = 3;
  localparam int          CODE_W       = 5;
  localparam int          DIV_W        = 3;
  localparam int          TS_W         = 3;
  localparam int          RES_W        = 10;
  localparam logic [7:0]  REG_RESET    = 8'h00;

  // ==================== channel, trigger and divider codes
  localparam logic [4:0]  CH_SE_LAST   = 5'h07;
  localparam logic [4:0]  CH_DIFF_1X   = 5'h10;
  localparam logic [4:0]  CH_BANDGAP   = 5'h1e;
  localparam logic [4:0]  CH_GND       = 5'h1f;
  localparam logic [2:0]  TS_FREE      = 3'h0;
  localparam logic [2:0]  DIV_MIN_CODE = 3'h1;

  // ==================== conversion lengths in converter clocks
  localparam logic [4:0]  FIRST_LEN    = 5'h19;
  localparam logic [4:0]  NORMAL_LEN   = 5'h0d;

  typedef enum logic [1:0] {
    ACC_GAIN_1X   = 2'h0,
    ACC_GAIN_10X  = 2'h1,
    ACC_GAIN_200X = 2'h2
  } acc_gain_e;

  typedef enum logic [1:0] {
    ACC_OFF  = 2'b00,
    ACC_IDLE = 2'b01,
    ACC_CONV = 2'b11
  } acc_state_e;

endpackage : acc_pkg

// *** hw/acc_tick_if.sv ***
// carrier between the controller and its converter clock divider
// assumes both ends sit on core_clk
`timescale 1ns/10ps
`default_nettype none
interface acc_tick_if;
  logic       run;
  logic       restart;
  logic [2:0] div_code;
  logic       tick;
  modport ctrl (output run, output restart, output div_code, input tick);
  modport gen  (input run, input restart, input div_code, output tick);
endinterface : acc_tick_if
`default_nettype wire

// *** hw/acc_prescaler.sv ***
// converter clock divider: one core_clk pulse per converter clock
// assumes synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module acc_prescaler
  import acc_pkg::*;
#(
  parameter int CNT_W = 7
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // divider control
  acc_tick_if.gen  tk
);
  import acc_pkg::*;

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] term;

  always_comb begin
    if (tk.div_code <= DIV_MIN_CODE) begin
      term = CNT_W'(1);
    end else begin
      term = CNT_W'((1 << tk.div_code) - 1);
    end
  end

  // count core clocks, pulse at terminal
  always_ff @(posedge core_clk) begin
    if (reset || !tk.run || tk.restart) begin
      cnt     <= '0;
      tk.tick <= 1'b0;
    end else if (cnt == term) begin
      cnt     <= '0;
      tk.tick <= 1'b1;
    end else begin
      cnt     <= cnt + CNT_W'(1);
      tk.tick <= 1'b0;
    end
  end

  // ticks never come back to back
  tick_gap_a: assert property (@(posedge core_clk) disable iff (reset) tk.tick |=> !tk.tick)
    else $error("converter clock ticks back to back");

endmodule : acc_prescaler
`default_nettype wire

// *** hw/acc_channel_decode.sv ***
// channel and gain code decoder for the analog input switches
// assumes the caller registers the outputs
`timescale 1ns/10ps
`default_nettype none
module acc_channel_decode
  import acc_pkg::*;
(
  // code in
  input  wire logic [4:0] code,
  // switch settings out
  output var  logic       single,
  output var  logic       diff,
  output var  logic       bandgap,
  output var  logic       ground,
  output var  logic [2:0] pos,
  output var  logic [2:0] neg,
  output var  acc_gain_e  gain
);
  import acc_pkg::*;

  always_comb begin
    single  = 1'b0;
    diff    = 1'b0;
    bandgap = 1'b0;
    ground  = 1'b0;
    pos     = code[2:0];
    neg     = 3'h0;
    gain    = ACC_GAIN_1X;
    if (code <= CH_SE_LAST) begin
      single = 1'b1;
    end else if (code == CH_BANDGAP) begin
      bandgap = 1'b1;
    end else if (code == CH_GND) begin
      ground = 1'b1;
    end else if (code < CH_DIFF_1X) begin
      diff = 1'b1;
      neg  = {1'b0, code[2], 1'b0};
      pos  = {1'b0, code[2], code[0]};
      gain = code[1] ? ACC_GAIN_200X : ACC_GAIN_10X;
    // unity pairs against input 1 or 2
    end else begin
      diff = 1'b1;
      neg  = code[3] ? 3'h2 : 3'h1;
    end
  end

endmodule : acc_channel_decode
`default_nettype wire

// *** verif/tb_top.sv ***
// ==================== converter control bench
// self-checking bench: apb register tasks and scenario sequences
// assumes acc_pkg, acc_tick_if, acc_prescaler, acc_channel_decode and acc_ctrl compile first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import acc_pkg::*;

  // ==================== signals
  logic                 core_clk, reset, psel, penable, pwrite;
  logic [ADDR_W-1:0]    paddr;
  logic [DATA_W-1:0]    pwdata, prdata, rq;
  logic                 pready, pslverr, re, cpu_irq_global_en, irq_ack, irq_req;
  logic [7:1]           trig_in;
  logic [RES_W-1:0]     sar_result;
  logic                 adc_power, adc_start, adc_busy, adc_single, adc_diff, adc_bandgap, adc_ground;
  logic [2:0]           adc_pos, adc_neg;
  acc_gain_e            adc_gain;
  int                   miscompares, checks_done;
  logic [16:0]          dec_tab [10];

  `define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

  // ==================== device under test
  acc_ctrl acc_ctrl_inst (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_in(trig_in), .cpu_irq_global_en(cpu_irq_global_en),
    .irq_ack(irq_ack), .irq_req(irq_req), .sar_result(sar_result), .adc_power(adc_power),
    .adc_start(adc_start), .adc_busy(adc_busy), .adc_single(adc_single), .adc_diff(adc_diff),
    .adc_bandgap(adc_bandgap), .adc_ground(adc_ground), .adc_pos(adc_pos), .adc_neg(adc_neg),
    .adc_gain(adc_gain));

  // ==================== clock, 4 ns period
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ==================== closing report
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      results();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    apb(a, 1'b0, 32'h0);
    `CHK("register read", {24'h0, e}, rq)
  endtask : rd_chk

  task automatic idle(input int c);
    repeat (c) @(posedge core_clk);
  endtask : idle

  // waits at least three cycles and until busy is low, then checks the length in core cycles
  // skip: core cycles of this conversion already gone before the call
  task automatic wait_chk(input int len, input int div, input int skip);
    int n;
    int st;
    n = 0;
    st = 0;
    do begin
      @(posedge core_clk);
      n++;
      st += (adc_start === 1'b1);
    end while ((adc_busy === 1'b1 || n < 3) && n < 5000);
    if (n >= 5000) begin
      miscompares++;
      results();
    end
    `CHK("conversion length", 1'b1, (n + skip >= len * div && n + skip <= len * div + 4))
    `CHK("start pulses", (skip == 0) ? 1 : 0, st)
  endtask : wait_chk

  task automatic conv(input logic [7:0] ctl, input int len, input int div);
    wr(OFF_CTRL, {24'h0, ctl});
    wait_chk(len, div, 0);
  endtask : conv

  // ==================== scenarios
  initial begin
    // {single, diff, bandgap, ground, pos, neg, gain, code}
    dec_tab = '{17'h10000, 17'h11c07, 17'h08429, 17'h0804a, 17'h08d4f, 17'h08090, 17'h08d2d, 17'h0401e,
                17'h0201f, 17'h0951d};
    miscompares = 0;
    checks_done = 0;
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, cpu_irq_global_en, irq_ack, trig_in} = '0;
    sar_result = 10'h2a5;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    rd_chk(OFF_CTRL, REG_RESET);
    rd_chk(OFF_SELECT, REG_RESET);
    apb(8'h20, 1'b0, 32'h0);
    `CHK("unmapped error", 1'b1, re)
    // channel decode table, idle converter
    foreach (dec_tab[i]) begin
      wr(OFF_SELECT, {27'h0, dec_tab[i][4:0]});
      idle(4);
      `CHK("decode flags", dec_tab[i][16:13], {adc_single, adc_diff, adc_bandgap, adc_ground})
      if (dec_tab[i][15] === 1'b1) begin
        `CHK("decode pair", dec_tab[i][12:5], {adc_pos, adc_neg, adc_gain})
      end else if (dec_tab[i][16] === 1'b1) begin
        `CHK("decode input", dec_tab[i][12:10], adc_pos)
      end
    end
    wr(OFF_SELECT, 32'h03);
    // first conversion after enable, then result and flag together
    conv(8'hc0, 25, 2);
    `CHK("power on", 1'b1, adc_power)
    rd_chk(OFF_CTRL, 8'h90);
    // low read locks result until high read
    rd_chk(OFF_RES_LOW, 8'ha5);
    sar_result <= 10'h15a;
    conv(8'hc0, 13, 2);
    rd_chk(OFF_RES_HIGH, 8'h02);
    conv(8'hc0, 13, 2);
    rd_chk(OFF_RES_LOW, 8'h5a);
    rd_chk(OFF_RES_HIGH, 8'h01);
    // flag clear by written one only
    wr(OFF_CTRL, 32'h80); // whole write, flag bit zero
    rd_chk(OFF_CTRL, 8'h90);
    wr(OFF_CTRL, 32'h90);
    rd_chk(OFF_CTRL, 8'h80);
    // interrupt gating and vector acknowledge
    cpu_irq_global_en <= 1'b1;
    conv(8'hc8, 13, 2);
    idle(2);
    `CHK("irq raised", 1'b1, irq_req)
    cpu_irq_global_en <= 1'b0;
    idle(3);
    `CHK("irq global off", 1'b0, irq_req)
    cpu_irq_global_en <= 1'b1;
    irq_ack <= 1'b1;
    @(posedge core_clk);
    irq_ack <= 1'b0;
    idle(3);
    `CHK("irq after ack", 1'b0, irq_req)
    rd_chk(OFF_CTRL, 8'h88);
    // channel change and zero start while converting
    wr(OFF_CTRL, 32'hc1);
    wr(OFF_SELECT, 32'h1f);
    wr(OFF_CTRL, 32'h81);
    idle(4);
    `CHK("code held", 2'b10, {adc_single, adc_ground})
    `CHK("zero start", 1'b1, adc_busy)
    wait_chk(13, 2, 12);
    idle(4);
    `CHK("code applied", 2'b01, {adc_single, adc_ground})
    // every divider code
    for (int c = 0; c < 8; c++) begin
      conv(8'hc0 | 8'(c), 13, (c < 2) ? 2 : (1 << c));
    end
    // abort by clearing enable
    wr(OFF_CTRL, 32'h90);
    wr(OFF_CTRL, 32'hc7);
    idle(20);
    wr(OFF_CTRL, 32'h00);
    idle(3);
    `CHK("abort", 2'b00, {adc_busy, adc_power})
    rd_chk(OFF_CTRL, 8'h00);
    // auto trigger from every source
    wr(OFF_CTRL, 32'ha0);
    for (int s = 1; s < 8; s++) begin
      wr(OFF_CTRL_B, 32'(s));
      trig_in <= 7'(1 << (s - 1));
      wait_chk((s == 1) ? 25 : 13, 2, 0);
      trig_in <= '0;
      wr(OFF_CTRL, 32'hb0);
    end
    // free running chains conversions
    wr(OFF_CTRL_B, 32'h0);
    wr(OFF_CTRL, 32'he0);
    idle(90);
    `CHK("free running", 1'b1, adc_busy)
    rd_chk(OFF_CTRL, 8'hf0);
    wr(OFF_CTRL, 32'h00);
    idle(3);
    `CHK("free stop", 1'b0, adc_busy)
    results();
  end

endmodule : tb_top
`default_nettype wire
